// File: core/dac_cmp_params.svh
// Register offsets, field positions and reset values of the converter and comparator control.
`ifndef DAC_CMP_PARAMS_SVH
`define DAC_CMP_PARAMS_SVH
`define OFF_CONV_EN_SRC 8'h00
`define OFF_CONV_LEVEL 8'h01
`define OFF_CMP1_CTRL0 8'h02
`define OFF_CMP1_CTRL1 8'h03
`define OFF_CMP1_PSEL 8'h04
`define OFF_CMP2_CTRL0 8'h05
`define OFF_CMP2_CTRL1 8'h06
`define OFF_CMP2_PSEL 8'h07
`define OFF_RESULT_MIRROR 8'h08
`define OFF_EVENT_FLAGS 8'h09
`define BIT_ON 7
`define BIT_PIN_ONE 5
`define BIT_PIN_TWO 4
`define BIT_SRC_LO 2
`define BIT_RES 6
`define BIT_POL 4
`define BIT_HYS 1
`define BIT_SYNC 0
`define BIT_INTP 1
`define BIT_INTN 0
`define MASK_CONV_EN_SRC 8'hbc
`define MASK_CONV_LEVEL 8'h1f
`define MASK_CTRL0_W 8'h93
`define MASK_CTRL1 8'h03
`define MASK_PSEL 8'h07
`define RST_REG 8'h00
`define SRC_RESERVED 2'h3
`endif

// File: core/dac_cmp_pkg.sv
// Types shared by the converter and comparator control.
package dac_cmp_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
  typedef struct packed {
    logic on;
    logic [1:0] source;
    logic [4:0] code;
    logic pin_one;
    logic pin_two;
  } conv_ctrl_s;
  typedef struct packed {
    logic on;
    logic invert;
    logic hyst;
    logic [2:0] pos_channel;
  } cmp_ctrl_s;
endpackage

// File: core/dac_cmp_ctrl.sv
// Converter and comparator control block with its register port.
//
// How it works
// - converter_on bit turns converter on.
// - five-bit level_code selects thirty-two levels.
// - source choice: supply, external pin, fixed reference.
// - pin enables connect level to pins.
// - level pin overrides digital driver, pull-up.
// - port read of level pin returns zero.
// - Sleep and wake leave converter untouched.
// - reset disables converter, clears code, pins.
// - unimplemented converter bits read as zero.
// - raw result high when plus above minus.
// - result_invert bit inverts the result.
// - comparator_on enables, clear gives lowest current.
// - result in own bit and shared mirror.
// - internal result latched every instruction cycle.
// - second comparator updates on oscillator rising edge.
// - second comparator offers low-power reference input.
// - hysteresis_on bit adds input hysteresis.
// - sync mode latches on Timer1 clock fall.
// - edge enables set comparator_event_flag.
// - first comparator control bit layout, zero reset.
`include "dac_cmp_params.svh"
`timescale 1ns/1ps
`default_nettype none
module dac_cmp_ctrl (
  input wire logic core_clk,
  input wire logic nrst,
  input wire dac_cmp_pkg::reg_req_s req,
  output logic [7:0] rdata,
  input wire logic [1:0] raw_compare,
  input wire logic low_freq_internal_osc,
  input wire logic timer1_src_clk,
  input wire logic sleep_mode,
  input wire logic [1:0] pin_read_in,
  output dac_cmp_pkg::conv_ctrl_s conv_ctrl,
  output dac_cmp_pkg::cmp_ctrl_s cmp1_ctrl,
  output dac_cmp_pkg::cmp_ctrl_s cmp2_ctrl,
  output logic [1:0] pin_digital_override,
  output logic [1:0] pin_read_value,
  output logic [1:0] comparator_result_bit,
  output logic [1:0] result_to_pin,
  output logic [1:0] result_to_timer1,
  output logic [1:0] comparator_event_flag
);
  import dac_cmp_pkg::*;

  // Register storage.
  logic [7:0] conv_en_src;
  logic [7:0] conv_level;
  logic [7:0] ctrl0 [2];
  logic [7:0] ctrl1 [2];
  logic [7:0] psel [2];
  logic [1:0] flags;
  // Synchronisers: stage one feeds stage two only.
  logic [1:0] cmp_s1, cmp_s2;
  logic osc_s1, osc_s2, osc_d;
  logic t1_s1, t1_s2, t1_d;
  logic [1:0] latched, latched_d, sync_out;
  logic c2_held;
  logic [1:0] pin_s1, pin_s2;
  // Start-up mask: edge detectors stay quiet until their history flops hold real samples.
  logic [2:0] warm;

  // A write to a converter register; the reserved source code is kept out of hardware.
  wire wr_conv0 = req.wr && req.addr == `OFF_CONV_EN_SRC;
  wire wr_conv1 = req.wr && req.addr == `OFF_CONV_LEVEL;
  wire [1:0] wr_src = req.wdata[`BIT_SRC_LO +: 2];
  wire src_ok = wr_src != `SRC_RESERVED;
  wire [7:0] next_conv_en_src = src_ok ? (req.wdata & `MASK_CONV_EN_SRC)
    : ((req.wdata & `MASK_CONV_EN_SRC & 8'hf3) | (conv_en_src & 8'h0c));
  wire wr_flags = req.wr && req.addr == `OFF_EVENT_FLAGS;

  // Edge detection of the oscillator and Timer1 source clock after synchronisers.
  // The history flop resets low whatever the pin does, so a pin that idles high
  // would fake a rising edge just after reset; warm[2] holds the detectors off.
  wire osc_rise = warm[2] && osc_s2 && !osc_d;
  wire t1_fall = warm[2] && !t1_s2 && t1_d;

  // Output after polarity, gated off while the comparator is disabled.
  function automatic logic apply_pol(input logic raw, input logic [7:0] c0);
    apply_pol = c0[`BIT_ON] & (raw ^ c0[`BIT_POL]);
  endfunction

  // The second comparator only takes a fresh sample on an oscillator rising edge.
  wire c1_now = apply_pol(cmp_s2[0], ctrl0[0]);
  wire c2_now = apply_pol(c2_held, ctrl0[1]);
  wire [1:0] result_now = {c2_now, c1_now};

  // Pin path is unlatched unless sync mode asks for the Timer1 copy.
  wire [1:0] sync_on = {ctrl0[1][`BIT_SYNC], ctrl0[0][`BIT_SYNC]};
  wire [1:0] next_pin_result = (sync_on & sync_out) | (~sync_on & result_now);
  wire [1:0] next_timer1_result = (sync_on & sync_out) | (~sync_on & latched);

  // Edge events chosen by the per-comparator enables.
  wire [1:0] rise = latched & ~latched_d;
  wire [1:0] fall = ~latched & latched_d;
  wire [1:0] ev = (rise & {ctrl1[1][`BIT_INTP], ctrl1[0][`BIT_INTP]})
    | (fall & {ctrl1[1][`BIT_INTN], ctrl1[0][`BIT_INTN]});

  // Read data mux; unmapped addresses read zero.
  function automatic logic [7:0] ctrl0_read(input logic [7:0] c0, input logic res);
    ctrl0_read = (c0 & `MASK_CTRL0_W) | (8'(res) << `BIT_RES);
  endfunction
  logic [7:0] next_rdata;
  always_comb begin
    unique case (req.addr)
      `OFF_CONV_EN_SRC: next_rdata = conv_en_src;
      `OFF_CONV_LEVEL: next_rdata = conv_level;
      `OFF_CMP1_CTRL0: next_rdata = ctrl0_read(ctrl0[0], latched[0]);
      `OFF_CMP1_CTRL1: next_rdata = ctrl1[0];
      `OFF_CMP1_PSEL: next_rdata = psel[0];
      `OFF_CMP2_CTRL0: next_rdata = ctrl0_read(ctrl0[1], latched[1]);
      `OFF_CMP2_CTRL1: next_rdata = ctrl1[1];
      `OFF_CMP2_PSEL: next_rdata = psel[1];
      `OFF_RESULT_MIRROR: next_rdata = {6'h00, latched};
      `OFF_EVENT_FLAGS: next_rdata = {6'h00, flags};
      default: next_rdata = 8'h00;
    endcase
  end

  // Converter registers: sleep does not touch them, only reset clears them.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      conv_en_src <= `RST_REG;
      conv_level <= `RST_REG;
    end else begin
      if (wr_conv0) begin
        conv_en_src <= next_conv_en_src;
      end
      if (wr_conv1) begin
        conv_level <= req.wdata & `MASK_CONV_LEVEL;
      end
    end
  end

  // Comparator control registers, one set per comparator.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 2; i++) begin
        ctrl0[i] <= `RST_REG;
        ctrl1[i] <= `RST_REG;
        psel[i] <= `RST_REG;
      end
    end else if (req.wr) begin
      for (int i = 0; i < 2; i++) begin
        if (req.addr == `OFF_CMP1_CTRL0 + 8'(3 * i)) ctrl0[i] <= req.wdata & `MASK_CTRL0_W;
        if (req.addr == `OFF_CMP1_CTRL1 + 8'(3 * i)) ctrl1[i] <= req.wdata & `MASK_CTRL1;
        if (req.addr == `OFF_CMP1_PSEL + 8'(3 * i)) psel[i] <= req.wdata & `MASK_PSEL;
      end
    end
  end

  // Synchronisers for the raw results and the two foreign clocks.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cmp_s1 <= 2'h0;
      cmp_s2 <= 2'h0;
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_d <= 1'b0;
      t1_s1 <= 1'b0;
      t1_s2 <= 1'b0;
      t1_d <= 1'b0;
      pin_s1 <= 2'h0;
      pin_s2 <= 2'h0;
      warm <= 3'h0;
    end else begin
      cmp_s1 <= raw_compare;
      cmp_s2 <= cmp_s1;
      osc_s1 <= low_freq_internal_osc;
      osc_s2 <= osc_s1;
      osc_d <= osc_s2;
      t1_s1 <= timer1_src_clk;
      t1_s2 <= t1_s1;
      t1_d <= t1_s2;
      pin_s1 <= pin_read_in;
      pin_s2 <= pin_s1;
      warm <= {warm[1:0], 1'b1};
    end
  end

  // Result latching, event flags and Timer1 synchronised copy.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      c2_held <= 1'b0;
      latched <= 2'h0;
      latched_d <= 2'h0;
      sync_out <= 2'h0;
      flags <= 2'h0;
    end else begin
      if (osc_rise) c2_held <= cmp_s2[1];
      latched <= result_now;
      latched_d <= latched;
      if (t1_fall) sync_out <= latched;
      // A new edge wins over a software clear in the same cycle.
      flags <= ((wr_flags ? flags & ~req.wdata[1:0] : flags)) | ev;
    end
  end

  // Read data stands for one cycle only, so a stale value never lingers on the bus.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= req.rd ? next_rdata : 8'h00;
    end
  end

  // Converter outputs towards the analog core and the pin logic.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      conv_ctrl <= '0;
      pin_digital_override <= 2'h0;
      pin_read_value <= 2'h0;
    end else begin
      conv_ctrl.on <= conv_en_src[`BIT_ON];
      conv_ctrl.source <= conv_en_src[`BIT_SRC_LO +: 2];
      conv_ctrl.code <= conv_level[4:0];
      conv_ctrl.pin_one <= conv_en_src[`BIT_PIN_ONE];
      conv_ctrl.pin_two <= conv_en_src[`BIT_PIN_TWO];
      pin_digital_override <= {conv_en_src[`BIT_PIN_TWO], conv_en_src[`BIT_PIN_ONE]};
      pin_read_value <= pin_s2 & ~{conv_en_src[`BIT_PIN_TWO], conv_en_src[`BIT_PIN_ONE]};
    end
  end

  // Comparator outputs; hysteresis and channel are only passed on to the analog core.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cmp1_ctrl <= '0;
      cmp2_ctrl <= '0;
      comparator_result_bit <= 2'h0;
      result_to_pin <= 2'h0;
      result_to_timer1 <= 2'h0;
      comparator_event_flag <= 2'h0;
    end else begin
      cmp1_ctrl <= '{ctrl0[0][`BIT_ON], ctrl0[0][`BIT_POL], ctrl0[0][`BIT_HYS], psel[0][2:0]};
      cmp2_ctrl <= '{ctrl0[1][`BIT_ON], ctrl0[1][`BIT_POL], ctrl0[1][`BIT_HYS], psel[1][2:0]};
      comparator_result_bit <= latched;
      result_to_pin <= next_pin_result;
      result_to_timer1 <= next_timer1_result;
      comparator_event_flag <= flags;
    end
  end

  // The flag is set one edge after an enabled rising or falling result.
  AST_RISE_FLAG: assert property (@(posedge core_clk) disable iff (!nrst)
    (rise[0] && ctrl1[0][`BIT_INTP]) |=> flags[0]) else $error("rise flag missed");
  AST_FALL_FLAG: assert property (@(posedge core_clk) disable iff (!nrst)
    (fall[1] && ctrl1[1][`BIT_INTN]) |=> flags[1]) else $error("fall flag missed");
  AST_OFF_ZERO: assert property (@(posedge core_clk) disable iff (!nrst)
    !ctrl0[0][`BIT_ON] |=> !latched[0]) else $error("disabled comparator output high");
  AST_POL: assert property (@(posedge core_clk) disable iff (!nrst)
    (ctrl0[0][`BIT_ON] && $stable(ctrl0[0]))
    |=> latched[0] == $past(cmp_s2[0] ^ ctrl0[0][`BIT_POL]))
    else $error("polarity wrong");
  AST_C2_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    !osc_rise |=> $stable(c2_held)) else $error("second comparator moved off edge");
  AST_SYNC_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    !t1_fall |=> $stable(sync_out)) else $error("sync copy moved off fall");
  AST_PIN_READ: assert property (@(posedge core_clk) disable iff (!nrst)
    conv_en_src[`BIT_PIN_ONE] |=> !pin_read_value[0]) else $error("level pin read not zero");
  AST_CODE_WR: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_conv1 |=> ##1 conv_ctrl.code == $past(req.wdata[4:0], 2)) else $error("code not applied");
  AST_CONV_MASK: assert property (@(posedge core_clk) disable iff (!nrst)
    conv_en_src[6] == 1'b0 && conv_en_src[1:0] == 2'h0 && conv_level[7:5] == 3'h0)
    else $error("unimplemented bit set");
  AST_ON: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_conv0 |=> ##1 conv_ctrl.on == $past(req.wdata[7], 2)) else $error("enable not applied");

  // Steps of the edge and steady-input behaviours, shared by the checks below.
  sequence seq_fall_seen;
    fall[0] && ctrl1[0][`BIT_INTN];
  endsequence
  sequence seq_rise_seen_two;
    rise[1] && ctrl1[1][`BIT_INTP];
  endsequence
  sequence seq_c1_steady;
    ctrl0[0][`BIT_ON] && !ctrl0[0][`BIT_POL] && $stable(ctrl0[0]) && $stable(cmp_s1[0]);
  endsequence

  // An enabled falling result of the first comparator sets its flag.
  AST_FALL_FLAG_ONE: assert property (@(posedge core_clk) disable iff (!nrst)
    seq_fall_seen |=> flags[0]) else $error("first fall flag missed");
  // An enabled rising result of the second comparator sets its flag.
  AST_RISE_FLAG_TWO: assert property (@(posedge core_clk) disable iff (!nrst)
    seq_rise_seen_two |=> flags[1]) else $error("second rise flag missed");
  // With steady inputs and plain polarity the latch follows the synchronised input.
  AST_C1_FOLLOW: assert property (@(posedge core_clk) disable iff (!nrst)
    seq_c1_steady |=> latched[0] == cmp_s2[0]) else $error("result does not follow");
  // The visible flags trail the sticky flags by one edge.
  AST_FLAG_OUT: assert property (@(posedge core_clk) disable iff (!nrst)
    1'b1 |=> comparator_event_flag == $past(flags)) else $error("flag output stale");
  // The result output bits trail the latch by one edge.
  AST_RESULT_OUT: assert property (@(posedge core_clk) disable iff (!nrst)
    1'b1 |=> comparator_result_bit == $past(latched)) else $error("result output stale");
  // The shared mirror read returns both latched results.
  AST_MIRROR_READ: assert property (@(posedge core_clk) disable iff (!nrst)
    (req.rd && req.addr == `OFF_RESULT_MIRROR) |=> rdata == {6'h00, $past(latched)})
    else $error("mirror read wrong");
  // Outside a read the data port stays at zero.
  AST_RD_IDLE: assert property (@(posedge core_clk) disable iff (!nrst)
    !req.rd |=> rdata == 8'h00) else $error("read data without read");
  // Unimplemented level bits read as zero.
  AST_LEVEL_READ: assert property (@(posedge core_clk) disable iff (!nrst)
    (req.rd && req.addr == `OFF_CONV_LEVEL) |=> rdata[7:5] == 3'h0)
    else $error("level read upper bits set");
  // Unimplemented source register bits read as zero.
  AST_SRC_READ: assert property (@(posedge core_clk) disable iff (!nrst)
    (req.rd && req.addr == `OFF_CONV_EN_SRC) |=> (rdata[6] == 1'b0 && rdata[1:0] == 2'h0))
    else $error("source read loose bits set");
  // A write with the reserved source code keeps the old source field.
  AST_SRC_KEEP: assert property (@(posedge core_clk) disable iff (!nrst)
    (wr_conv0 && !src_ok) |=> conv_en_src[3:2] == $past(conv_en_src[3:2]))
    else $error("reserved source taken");
  // Sleep alone never changes the converter enable and source register.
  AST_SLEEP_KEEP: assert property (@(posedge core_clk) disable iff (!nrst)
    (sleep_mode && !wr_conv0) |=> $stable(conv_en_src)) else $error("sleep moved converter");
  // Each enabled level pin has its digital functions overridden.
  AST_OVERRIDE: assert property (@(posedge core_clk) disable iff (!nrst)
    1'b1 |=> pin_digital_override == $past({conv_en_src[`BIT_PIN_TWO], conv_en_src[`BIT_PIN_ONE]}))
    else $error("override wrong");
  // The second level pin also reads as zero while enabled.
  AST_PIN_TWO_READ: assert property (@(posedge core_clk) disable iff (!nrst)
    conv_en_src[`BIT_PIN_TWO] |=> !pin_read_value[1]) else $error("pin two read not zero");
  // A disabled second comparator shows a low result.
  AST_C2_OFF: assert property (@(posedge core_clk) disable iff (!nrst)
    !ctrl0[1][`BIT_ON] |=> !latched[1]) else $error("disabled second comparator high");
  // The CTRL0 registers of both comparators keep their unimplemented bits clear.
  AST_CTRL_MASK: assert property (@(posedge core_clk) disable iff (!nrst)
    (ctrl0[0] & ~`MASK_CTRL0_W) == 8'h00 && (ctrl0[1] & ~`MASK_CTRL0_W) == 8'h00)
    else $error("control loose bit set");
  // In sync mode the Timer1 path shows the copy taken on the clock fall.
  AST_SYNC_TIMER: assert property (@(posedge core_clk) disable iff (!nrst)
    ctrl0[0][`BIT_SYNC] |=> result_to_timer1[0] == $past(sync_out[0]))
    else $error("sync timer path wrong");
  // Without sync the Timer1 path shows the latched result.
  AST_ASYNC_TIMER: assert property (@(posedge core_clk) disable iff (!nrst)
    !ctrl0[0][`BIT_SYNC] |=> result_to_timer1[0] == $past(latched[0]))
    else $error("timer path wrong");
  // Without sync the pin path bypasses the latch.
  AST_PIN_UNLATCHED: assert property (@(posedge core_clk) disable iff (!nrst)
    !ctrl0[0][`BIT_SYNC] |=> result_to_pin[0] == $past(result_now[0]))
    else $error("pin path latched");
endmodule
`default_nettype wire

// File: verification/tb_dac_cmp_ctrl.sv
// Self-checking bench for the converter and comparator control block.
`include "dac_cmp_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_dac_cmp_ctrl;
  import dac_cmp_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  reg_req_s req = '0;
  logic [1:0] raw_compare = 2'h0;
  logic low_freq_internal_osc = 1'b0;
  logic timer1_src_clk = 1'b1;
  logic sleep_mode = 1'b0;
  logic [1:0] pin_read_in = 2'h0;
  logic [7:0] rdata;
  conv_ctrl_s conv_ctrl;
  cmp_ctrl_s cmp1_ctrl;
  cmp_ctrl_s cmp2_ctrl;
  logic [1:0] pin_digital_override, pin_read_value, comparator_result_bit;
  logic [1:0] result_to_pin, result_to_timer1, comparator_event_flag;
  logic [7:0] obs;
  int fails = 0;
  int checked = 0;
  integer seed = 90;
  logic [7:0] got, d, e;
  logic [1:0] src = 2'h0;
  // Flat view of the result outputs so one bounded wait serves them all.
  assign obs = {result_to_pin, comparator_event_flag, result_to_timer1, comparator_result_bit};
  // Free-running core clock, 100 ns period.
  always #50 core_clk = ~core_clk;
  dac_cmp_ctrl dut_u (.core_clk(core_clk), .nrst(nrst), .req(req), .rdata(rdata),
    .raw_compare(raw_compare), .low_freq_internal_osc(low_freq_internal_osc),
    .timer1_src_clk(timer1_src_clk), .sleep_mode(sleep_mode), .pin_read_in(pin_read_in),
    .conv_ctrl(conv_ctrl), .cmp1_ctrl(cmp1_ctrl), .cmp2_ctrl(cmp2_ctrl),
    .pin_digital_override(pin_digital_override), .pin_read_value(pin_read_value),
    .comparator_result_bit(comparator_result_bit), .result_to_pin(result_to_pin),
    .result_to_timer1(result_to_timer1), .comparator_event_flag(comparator_event_flag));
  task automatic test_done;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask
  // Read data only stands in the cycle after the strobe, so sample it there.
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Bounded wait on one observed bit; a timeout closes the run at once.
  task automatic await(input int s, input logic x);
    int i;
    for (i = 0; i < 40 && obs[s] !== x; i++) @(posedge core_clk) #1;
    chk("observed bit", {7'h0, obs[s]}, {7'h0, x});
    if (i == 40) test_done();
  endtask
  // Expected source register: a reserved source code leaves the old field.
  function automatic logic [7:0] conv_exp(input logic [7:0] v, input logic [1:0] old);
    return {v[7], 1'b0, v[5:4], (v[3:2] == `SRC_RESERVED) ? old : v[3:2], 2'b00};
  endfunction
  // Main sequence: reset values, random register traffic, then result paths.
  initial begin
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    for (int a = 0; a < 11; a++) begin
      rd(a[7:0], got);
      chk("reset read", got, `RST_REG);
    end
    for (int k = 0; k < 12; k++) begin
      d = (k == 0) ? 8'hfc : 8'($random(seed));
      @(posedge core_clk);
      pin_read_in <= d[1:0];
      sleep_mode <= k[0];
      wr(`OFF_CONV_EN_SRC, d);
      e = conv_exp(d, src);
      src = e[3:2];
      cyc(2);
      rd(`OFF_CONV_EN_SRC, got);
      chk("source reg", got, e);
      chk("conv on", {7'h0, conv_ctrl.on}, {7'h0, d[7]});
      chk("pins", {6'h0, conv_ctrl.pin_one, conv_ctrl.pin_two}, {6'h0, d[5:4]});
      chk("override", {6'h0, pin_digital_override}, {6'h0, d[4], d[5]});
      chk("pin read", {6'h0, pin_read_value}, {6'h0, d[1:0] & ~{d[4], d[5]}});
      wr(`OFF_CONV_LEVEL, ~d);
      cyc(2);
      rd(`OFF_CONV_LEVEL, got);
      chk("level reg", got, ~d & `MASK_CONV_LEVEL);
      chk("level code", {3'h0, conv_ctrl.code}, ~d & 8'h1f);
      rd(`OFF_CONV_EN_SRC, got);
      chk("kept in sleep", got, e);
    end
    for (int k = 0; k < 8; k++) begin
      d = 8'($random(seed));
      wr(`OFF_CMP1_CTRL0, d);
      wr(`OFF_CMP2_CTRL0, ~d);
      wr(`OFF_CMP2_PSEL, d);
      wr(`OFF_CMP1_CTRL1, d);
      cyc(2);
      rd(`OFF_CMP1_CTRL0, got);
      chk("ctrl0", got & 8'hbf, d & `MASK_CTRL0_W);
      chk("cmp1 ctrl", {5'h0, cmp1_ctrl.on, cmp1_ctrl.invert, cmp1_ctrl.hyst},
        {5'h0, d[7], d[4], d[1]});
      chk("cmp2 hyst", {7'h0, cmp2_ctrl.hyst}, {7'h0, ~d[1]});
      chk("channel", {5'h0, cmp2_ctrl.pos_channel}, d & `MASK_PSEL);
      rd(`OFF_CMP1_CTRL1, got);
      chk("ctrl1", got, d & `MASK_CTRL1);
    end
    wr(`OFF_CMP1_CTRL1, 8'h00);
    wr(`OFF_CMP2_CTRL0, 8'h00);
    for (int p = 0; p < 4; p++) begin
      wr(`OFF_CMP1_CTRL0, {3'h4, p[1], 4'h0});
      @(posedge core_clk);
      raw_compare[0] <= p[0];
      cyc(6);
      await(0, p[0] ^ p[1]);
      await(6, p[0] ^ p[1]);
      rd(`OFF_RESULT_MIRROR, got);
      chk("mirror", got & 8'h01, {7'h0, p[0] ^ p[1]});
      rd(`OFF_CMP1_CTRL0, got);
      chk("own bit", {7'h0, got[6]}, {7'h0, p[0] ^ p[1]});
    end
    // The second comparator must ignore its input until the oscillator rises.
    wr(`OFF_CMP2_CTRL0, 8'h80);
    raw_compare[1] <= 1'b1;
    cyc(12);
    chk("cmp2 held", {7'h0, comparator_result_bit[1]}, 8'h00);
    low_freq_internal_osc <= 1'b1;
    await(1, 1'b1);
    wr(`OFF_EVENT_FLAGS, 8'hff);
    wr(`OFF_CMP1_CTRL0, 8'h80);
    wr(`OFF_CMP1_CTRL1, 8'h02);
    raw_compare[0] <= 1'b0;
    await(0, 1'b0);
    cyc(3);
    chk("no fall flag", {7'h0, comparator_event_flag[0]}, 8'h00);
    raw_compare[0] <= 1'b1;
    await(4, 1'b1);
    wr(`OFF_EVENT_FLAGS, 8'h01);
    cyc(3);
    rd(`OFF_EVENT_FLAGS, got);
    chk("flag cleared", got, 8'h00);
    wr(`OFF_CMP1_CTRL1, 8'h01);
    raw_compare[0] <= 1'b0;
    await(4, 1'b1);
    // Synchronised mode only follows the input on a Timer1 clock fall.
    wr(`OFF_CMP1_CTRL0, 8'h81);
    timer1_src_clk <= 1'b0;
    cyc(6);
    timer1_src_clk <= 1'b1;
    await(2, 1'b0);
    raw_compare[0] <= 1'b1;
    cyc(12);
    chk("sync held", {7'h0, result_to_timer1[0]}, 8'h00);
    timer1_src_clk <= 1'b0;
    await(2, 1'b1);
    await(6, 1'b1);
    wr(`OFF_CONV_EN_SRC, 8'hb8);
    wr(`OFF_CONV_LEVEL, 8'h1f);
    cyc(2);
    nrst <= 1'b0;
    cyc(2);
    nrst <= 1'b1;
    #1 chk("conv after reset", {6'h0, conv_ctrl.on, conv_ctrl.pin_one}, 8'h00);
    rd(`OFF_CONV_LEVEL, got);
    chk("code after reset", got, 8'h00);
    test_done();
  end
endmodule
`default_nettype wire
